// ---- pxsc_pkg.sv ----
// package for the per-port crossover special control register
// assumes a management access port of 5-bit index and 16-bit data
package pxsc_pkg;
  localparam logic [4:0]  REG_INDEX      = 5'h1B;
  localparam logic [15:0] REG_RESET      = 16'h0000;
  localparam int          BIT_SRC_SEL    = 15;
  localparam int          BIT_AUTO_EN    = 14;
  localparam int          BIT_STATE      = 13;
  localparam int          BIT_HB_DIS     = 11;
  localparam int          BIT_PLL_REF    = 10;
  localparam int          BIT_POLARITY   = 4;
  localparam logic [15:0] WRITABLE_MASK  = 16'hEC00;
  localparam int          SYNC_STAGES    = 3;

  typedef enum logic [1:0] {
    PXSC_MODE_STRAIGHT,
    PXSC_MODE_CROSS,
    PXSC_MODE_AUTO
  } pxsc_mode_t;
endpackage : pxsc_pkg

// ---- pxsc_sync_if.sv ----
// interface carrying a synchronised level between the top and its filter
// assumes one clock shared by both ends
`timescale 1ns/10ps
`default_nettype none
interface pxsc_sync_if;
  logic raw;
  logic stable;
  modport filt (input raw, output stable);
  modport user (output raw, input stable);
endinterface : pxsc_sync_if
`default_nettype wire

// ---- pxsc_sync.sv ----
// three-stage input synchroniser; change accepted when stages 2 and 3 agree
// assumes an asynchronous reset, active high
`timescale 1ns/10ps
`default_nettype none
module pxsc_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic  i_clk,
  input  wire logic  i_rst,
  pxsc_sync_if.filt  s
);
  logic [2:0] stage;
  logic       held;
  logic [2:0] next_stage;
  logic       next_held;

  always_comb begin
    next_stage = {stage[1:0], s.raw};
    next_held  = held;
    // first stage feeds only the second
    if (stage[1] == stage[2]) begin
      next_held = stage[2];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stage <= {3{RESET_VAL}};
      held  <= RESET_VAL;
    end else begin
      stage <= next_stage;
      held  <= next_held;
    end
  end

  assign s.stable = held;
endmodule : pxsc_sync
`default_nettype wire

// ---- pxsc_top.sv ----
// crossover special control register bank for one PHY port
// assumes management reads/writes as index+strobe, strap pins asynchronous
//
// Summary of operation
// - source select 1: straps ignored, register bits set crossover mode
// - source select 0 (default): latched straps set crossover mode
// - strap auto 1 gives auto; else manual 0 straight, 1 crossover
// - register bits 14:13: 00 straight, 01 crossover, 10 auto
// - bit 11 set disables heartbeat test; reset 0 keeps it enabled
// - bit 10 set forces 10M receive PLL onto reference clock
// - from one cycle after PLL forced to reference, no 10M frames reported valid
// - read-only bit 4 shows 10BASE-T polarity, 1 reversed
// - port PHY reset from chip reset control clears control bits
// - PHY soft reset leaves control bits unchanged
// - latched auto crossover strap readable in hardware config register
// - straps captured on the fifth clock after chip reset release, then used
`timescale 1ns/10ps
`default_nettype none
module pxsc_top (
  input  wire logic         I_CLK_SYS,
  input  wire logic         I_RST,
  input  wire logic         i_mgmt_sel,
  input  wire logic         i_mgmt_wr,
  input  wire logic         i_mgmt_rd,
  input  wire logic [4:0]   i_mgmt_index,
  input  wire logic [15:0]  i_mgmt_wdata,
  output logic      [15:0]  o_mgmt_rdata,
  output logic              o_mgmt_rvalid,
  input  wire logic         i_port_phy_reset,
  input  wire logic         i_phy_soft_reset,
  input  wire logic         i_auto_crossover_strap,
  input  wire logic         i_manual_crossover_strap,
  input  wire logic         i_ten_meg_polarity_reversed,
  input  wire logic         i_rx10_frame_valid,
  output logic      [1:0]   o_crossover_mode,
  output logic              o_heartbeat_test_disable,
  output logic              o_rx_pll_force_reference,
  output logic              o_rx10_frame_valid,
  output logic              o_auto_crossover_strap_state
);
  pxsc_sync_if auto_if ();
  pxsc_sync_if man_if ();
  pxsc_sync_if pol_if ();

  assign auto_if.raw = i_auto_crossover_strap;
  assign man_if.raw  = i_manual_crossover_strap;
  assign pol_if.raw  = i_ten_meg_polarity_reversed;

  pxsc_sync #(.RESET_VAL(1'b0)) u_sync_auto (
    .i_clk (I_CLK_SYS),
    .i_rst (I_RST),
    .s     (auto_if)
  );
  pxsc_sync #(.RESET_VAL(1'b0)) u_sync_man (
    .i_clk (I_CLK_SYS),
    .i_rst (I_RST),
    .s     (man_if)
  );
  pxsc_sync #(.RESET_VAL(1'b0)) u_sync_pol (
    .i_clk (I_CLK_SYS),
    .i_rst (I_RST),
    .s     (pol_if)
  );

  // strap capture: waits for the synchroniser to fill after release
  logic [2:0] cap_cnt;
  logic       strap_latched;
  logic       strap_auto;
  logic       strap_manual;
  logic [2:0] next_cap_cnt;
  logic       next_strap_latched;
  logic       next_strap_auto;
  logic       next_strap_manual;

  always_comb begin
    next_cap_cnt       = cap_cnt;
    next_strap_latched = strap_latched;
    next_strap_auto    = strap_auto;
    next_strap_manual  = strap_manual;
    if (!strap_latched) begin
      // one edge beyond the stage count: the filtered level settles
      // only after the second and third stages have agreed
      if (cap_cnt == 3'(pxsc_pkg::SYNC_STAGES + 1)) begin
        next_strap_latched = 1'b1;
        next_strap_auto    = auto_if.stable;
        next_strap_manual  = man_if.stable;
      end else begin
        next_cap_cnt = cap_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      cap_cnt       <= 3'h0;
      strap_latched <= 1'b0;
      strap_auto    <= 1'b0;
      strap_manual  <= 1'b0;
    end else begin
      cap_cnt       <= next_cap_cnt;
      strap_latched <= next_strap_latched;
      strap_auto    <= next_strap_auto;
      strap_manual  <= next_strap_manual;
    end
  end

  // control bits
  logic [15:0] ctrl;
  logic [15:0] next_ctrl;
  logic        hit;

  assign hit = i_mgmt_sel && (i_mgmt_index == pxsc_pkg::REG_INDEX);

  always_comb begin
    next_ctrl = ctrl;
    if (i_port_phy_reset) begin
      next_ctrl = pxsc_pkg::REG_RESET;
    end else if (hit && i_mgmt_wr) begin
      next_ctrl = i_mgmt_wdata & pxsc_pkg::WRITABLE_MASK;
    end
    // soft reset ignored here: i_phy_soft_reset has no effect
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      ctrl <= pxsc_pkg::REG_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // crossover mode decode
  pxsc_pkg::pxsc_mode_t mode;
  always_comb begin
    mode = pxsc_pkg::PXSC_MODE_STRAIGHT;
    if (ctrl[pxsc_pkg::BIT_SRC_SEL]) begin
      // register decode; 11 reserved, treated as auto
      unique case ({ctrl[pxsc_pkg::BIT_AUTO_EN], ctrl[pxsc_pkg::BIT_STATE]})
        2'b00:   mode = pxsc_pkg::PXSC_MODE_STRAIGHT;
        2'b01:   mode = pxsc_pkg::PXSC_MODE_CROSS;
        default: mode = pxsc_pkg::PXSC_MODE_AUTO;
      endcase
    end else begin
      if (strap_auto) begin
        mode = pxsc_pkg::PXSC_MODE_AUTO;
      end else if (strap_manual) begin
        mode = pxsc_pkg::PXSC_MODE_CROSS;
      end else begin
        mode = pxsc_pkg::PXSC_MODE_STRAIGHT;
      end
    end
  end

  // outputs registered
  logic [1:0]  mode_q;
  logic        rx_valid_q;
  logic [15:0] rdata_q;
  logic        rvalid_q;
  logic [15:0] next_rdata;
  logic        next_rvalid;
  logic        next_rx_valid;

  always_comb begin
    next_rdata = 16'h0000;
    next_rvalid = 1'b0;
    next_rx_valid = i_rx10_frame_valid && !ctrl[pxsc_pkg::BIT_PLL_REF];
    if (hit && i_mgmt_rd) begin
      next_rvalid = 1'b1;
      next_rdata  = ctrl & pxsc_pkg::WRITABLE_MASK;
      next_rdata[pxsc_pkg::BIT_POLARITY] = pol_if.stable;
    end else if (i_mgmt_sel && i_mgmt_rd) begin
      // other indexes belong elsewhere; answer zero
      next_rvalid = 1'b1;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      mode_q     <= 2'h0;
      rx_valid_q <= 1'b0;
      rdata_q    <= 16'h0000;
      rvalid_q   <= 1'b0;
    end else begin
      mode_q     <= mode;
      rx_valid_q <= next_rx_valid;
      rdata_q    <= next_rdata;
      rvalid_q   <= next_rvalid;
    end
  end

  assign o_crossover_mode = mode_q;
  assign o_heartbeat_test_disable = ctrl[pxsc_pkg::BIT_HB_DIS];
  assign o_rx_pll_force_reference = ctrl[pxsc_pkg::BIT_PLL_REF];
  assign o_rx10_frame_valid = rx_valid_q;
  assign o_mgmt_rdata = rdata_q;
  assign o_mgmt_rvalid = rvalid_q;
  assign o_auto_crossover_strap_state = strap_auto;
endmodule : pxsc_top
`default_nettype wire

// ---- pxsc_checker.sv ----
// assertions for the crossover special control register bank
// assumes a bind onto pxsc_top; sees only its ports
`timescale 1ns/10ps
`default_nettype none
module pxsc_checker (
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RST,
  input  wire logic        i_mgmt_sel,
  input  wire logic        i_mgmt_wr,
  input  wire logic [4:0]  i_mgmt_index,
  input  wire logic [15:0] i_mgmt_wdata,
  input  wire logic [15:0] o_mgmt_rdata,
  input  wire logic        o_mgmt_rvalid,
  input  wire logic        i_port_phy_reset,
  input  wire logic        i_phy_soft_reset,
  input  wire logic        i_rx10_frame_valid,
  input  wire logic [1:0]  o_crossover_mode,
  input  wire logic        o_heartbeat_test_disable,
  input  wire logic        o_rx_pll_force_reference,
  input  wire logic        o_rx10_frame_valid
);
  // port reset beats a same-cycle write
  wire hit = i_mgmt_sel && i_mgmt_wr && i_mgmt_index == 5'h1B
             && !i_port_phy_reset;
  wire quiet = !(i_mgmt_sel && i_mgmt_wr) && !i_port_phy_reset;
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);
  property p_rsv;
    o_mgmt_rvalid |-> (o_mgmt_rdata & 16'h13EF) == 16'h0000;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_hb;
    hit |=> o_heartbeat_test_disable == $past(i_mgmt_wdata[11]);
  endproperty
  a_hb: assert property (p_hb) else $error("heartbeat bit");
  property p_pll;
    hit |=> o_rx_pll_force_reference == $past(i_mgmt_wdata[10]);
  endproperty
  a_pll: assert property (p_pll) else $error("pll bit");
  property p_prst;
    i_port_phy_reset |=> !o_heartbeat_test_disable
      && !o_rx_pll_force_reference;
  endproperty
  a_prst: assert property (p_prst) else $error("port reset");
  property p_soft;
    i_phy_soft_reset && quiet |=> $stable(o_heartbeat_test_disable)
      && $stable(o_rx_pll_force_reference);
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset");
  property p_block;
    o_rx_pll_force_reference ##1 o_rx_pll_force_reference
      |-> !o_rx10_frame_valid;
  endproperty
  a_block: assert property (p_block) else $error("frame passed");
  property p_pass;
    !o_rx_pll_force_reference && i_rx10_frame_valid
      ##1 !o_rx_pll_force_reference |-> o_rx10_frame_valid;
  endproperty
  a_pass: assert property (p_pass) else $error("frame lost");
  property p_mode;
    hit && i_mgmt_wdata[15] ##1 quiet |=> o_crossover_mode ==
      ($past(i_mgmt_wdata[14], 2) ? 2'h2 : {1'h0, $past(i_mgmt_wdata[13], 2)});
  endproperty
  a_mode: assert property (p_mode) else $error("mode decode");
  c_auto: cover property (o_crossover_mode == 2'h2);
  c_block: cover property (o_rx_pll_force_reference && i_rx10_frame_valid);
  c_pol: cover property (o_mgmt_rvalid && o_mgmt_rdata[4]);
endmodule : pxsc_checker
`default_nettype wire

// ---- pxsc_top_test.sv ----
// self-checking bench for pxsc_top
// assumes pxsc_checker is compiled ahead of this file
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin mismatches++; \
  $display("ERROR %s exp %h got %h", n, e, a); end end
module pxsc_top_test;
  typedef struct packed { logic [15:0] w, r; logic [1:0] m; } pxsc_row_t;
  logic I_CLK_SYS, I_RST, i_mgmt_sel, i_mgmt_wr, i_mgmt_rd, i_port_phy_reset;
  logic i_phy_soft_reset, i_auto_crossover_strap, i_manual_crossover_strap;
  logic i_ten_meg_polarity_reversed, i_rx10_frame_valid, o_mgmt_rvalid;
  logic o_heartbeat_test_disable, o_rx_pll_force_reference;
  logic o_rx10_frame_valid, o_auto_crossover_strap_state;
  logic [4:0]  i_mgmt_index;
  logic [15:0] i_mgmt_wdata, o_mgmt_rdata;
  logic [1:0]  o_crossover_mode;
  int          mismatches, checked, i;
  // last row falls back to straps: manual strap high gives crossover
  // no row sets bits 14 and 13 together
  pxsc_row_t   rows [4] = '{'{16'h8000, 16'h8000, 2'h0},
    '{16'hA000, 16'hA000, 2'h1}, '{16'hC400, 16'hC400, 2'h2},
    '{16'h1BFF, 16'h0800, 2'h1}};
  pxsc_top u_pxsc_top (.*);
  always #5 I_CLK_SYS = ~I_CLK_SYS;
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge I_CLK_SYS);
    {i_mgmt_sel, i_mgmt_wr, i_mgmt_index, i_mgmt_wdata} <= {2'h3, a, d};
    @(posedge I_CLK_SYS);
    {i_mgmt_sel, i_mgmt_wr} <= 2'h0;
  endtask : wr
  task automatic rdc(input logic [4:0] a, input logic [15:0] e);
    @(posedge I_CLK_SYS);
    {i_mgmt_sel, i_mgmt_rd, i_mgmt_index} <= {2'h3, a};
    @(posedge I_CLK_SYS);
    {i_mgmt_sel, i_mgmt_rd} <= 2'h0;
    #1;
    `CHK("rvalid", 1'h1, o_mgmt_rvalid)
    `CHK("rdata", e, o_mgmt_rdata)
  endtask : rdc
  task automatic rst;
    I_RST <= 1'h1;
    repeat (16) @(posedge I_CLK_SYS);
    I_RST <= 1'h0;
    repeat (8) @(posedge I_CLK_SYS);
    #1;
  endtask : rst
  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  initial begin
    #100000;
    mismatches++;
    finish_test();
  end
  initial begin
    {I_CLK_SYS, I_RST, i_mgmt_sel, i_mgmt_wr, i_mgmt_rd} = 5'h08;
    {i_port_phy_reset, i_phy_soft_reset, i_auto_crossover_strap} = 3'h0;
    {i_manual_crossover_strap, i_ten_meg_polarity_reversed} = 2'h2;
    {i_rx10_frame_valid, i_mgmt_index, i_mgmt_wdata} = 22'h000000;
    rst();
    rdc(5'h1B, 16'h0000);
    `CHK("strap", 1'h0, o_auto_crossover_strap_state)
    `CHK("mode", 2'h1, o_crossover_mode)
    $display("reset test done");
    for (i = 0; i < 4; i++) begin
      wr(5'h1B, rows[i].w);
      rdc(5'h1B, rows[i].r);
      `CHK("mode", rows[i].m, o_crossover_mode)
      `CHK("hb", rows[i].r[11], o_heartbeat_test_disable)
      `CHK("pll", rows[i].r[10], o_rx_pll_force_reference)
    end
    $display("table test done");
    i_auto_crossover_strap <= 1'h1;
    rst();
    `CHK("strap", 1'h1, o_auto_crossover_strap_state)
    `CHK("mode", 2'h2, o_crossover_mode)
    i_auto_crossover_strap <= 1'h0;
    repeat (8) @(posedge I_CLK_SYS);
    `CHK("mode", 2'h2, o_crossover_mode)
    wr(5'h1B, 16'h8000);
    rdc(5'h1B, 16'h8000);
    `CHK("mode", 2'h0, o_crossover_mode)
    $display("strap test done");
    wr(5'h1B, 16'hCC00);
    i_phy_soft_reset <= 1'h1;
    @(posedge I_CLK_SYS) i_phy_soft_reset <= 1'h0;
    rdc(5'h1B, 16'hCC00);
    i_port_phy_reset <= 1'h1;
    @(posedge I_CLK_SYS) i_port_phy_reset <= 1'h0;
    rdc(5'h1B, 16'h0000);
    $display("reset kinds test done");
    i_ten_meg_polarity_reversed <= 1'h1;
    i_rx10_frame_valid <= 1'h1;
    repeat (4) @(posedge I_CLK_SYS);
    wr(5'h1B, 16'h0400);
    rdc(5'h1B, 16'h0410);
    `CHK("frame", 1'h0, o_rx10_frame_valid)
    wr(5'h1B, 16'h0000);
    rdc(5'h1B, 16'h0010);
    `CHK("frame", 1'h1, o_rx10_frame_valid)
    $display("frame test done");
    wr(5'h1A, 16'hFFFF);
    rdc(5'h1A, 16'h0000);
    rdc(5'h1B, 16'h0010);
    $display("index test done");
    finish_test();
  end
endmodule : pxsc_top_test
bind pxsc_top pxsc_checker u_pxsc_checker (.*);
`default_nettype wire
